// >>> dv/emsp_phy.sv
// emsp_phy: behavioural external phy on the mii and mdio pins
// assumes free running nibble clocks; mdio strap resistor pulls high
module emsp_phy
(
  output logic       tx_clk,
  output logic       rx_clk,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  output logic [3:0] rxd,
  output logic       rx_dv,
  output logic       rx_er,
  output logic       col,
  output logic       crs,
  input  wire logic       mdio_o,
  input  wire logic       mdio_oe,
  output logic       mdio_i,
  input  wire logic       go,
  input  wire logic       bad,
  input  wire logic       hit,
  output logic [15:0] got,
  output logic [3:0]  cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pat [4] = '{4'ha, 4'h5, 4'hc, 4'h3};
  // both nibble clocks run free, rx offset so they share no phase
  initial
  begin
    tx_clk = 1'b0;
    forever #40 tx_clk = ~tx_clk;
  end
  initial
  begin
    rx_clk = 1'b0;
    #13;
    forever #40 rx_clk = ~rx_clk;
  end
  // phy takes a nibble on each tx_clk rise while enabled
  // one process owns the capture state, so it has a single driver
  initial
  begin
    got = '0;
    cnt = '0;
    forever
    begin
      @(posedge tx_clk);
      if (tx_en)
      begin
        got <= {got[11:0], txd};
        cnt <= cnt + 4'h1;
      end
    end
  end
  // four nibble frame, changed after rx_clk falls
  initial
  begin
    {rx_dv, rx_er} = 2'b00;
    rxd = 4'h1;
    forever
    begin
      @(posedge go);
      for (int i = 0; i < 4; i++)
      begin
        @(negedge rx_clk);
        rxd = pat[i];
        rx_dv = 1'b1;
        rx_er = bad && i == 2;
      end
      @(negedge rx_clk);
      {rx_dv, rx_er} = 2'b00;
      rxd = {3'b000, ~rxd[0]}; // bit 0 has no pull-down, so it wanders
    end
  end
  // collision on demand, carrier during frames
  assign col = hit;
  assign crs = rx_dv | hit;
  // strap resistor reports a phy when nobody drives
  assign mdio_i = mdio_oe ? mdio_o : 1'b1;
endmodule

// >>> dv/emsp_sva.sv
// emsp_sva: port checks for emsp_port
// assumes a bind onto emsp_port and one core clock domain
module emsp_sva
(
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       ext_phy_selected,
  input wire logic       external_mgmt_port_select,
  input wire logic       mac_tx_taken,
  input wire logic       mac_rx_valid,
  input wire logic       mac_rx_frame_end,
  input wire logic       mac_rx_frame_err,
  input wire logic       mac_col,
  input wire logic       mac_crs,
  input wire logic       mgmt_out,
  input wire logic       mgmt_drive,
  input wire logic [3:0] txd,
  input wire logic       tx_en,
  input wire logic       mdc,
  input wire logic       mdio_o,
  input wire logic       mdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // internal path must leave the phy no transmit request
  int_txd_a: assert property (!ext_phy_selected |=> txd == 4'h0)
    else $error("txd not low on internal path");
  int_txen_a: assert property (!ext_phy_selected |=> !tx_en)
    else $error("tx_en high on internal path");
  taken_txen_a: assert property (mac_tx_taken |-> tx_en)
    else $error("nibble taken without tx_en");
  sel_mdc_a: assert property (
      !external_mgmt_port_select |=> !mdc)
    else $error("mdc not low while deselected");
  sel_mdio_a: assert property (
      !external_mgmt_port_select |=> !mdio_oe)
    else $error("mdio driven while deselected");
  mdio_follow_a: assert property (
      mdio_oe |-> mdio_o == $past(mgmt_out) && $past(mgmt_drive)
      && $past(external_mgmt_port_select))
    else $error("mdio drive not from management side");
  mdc_sel_a: assert property (
      $rose(mdc) |-> $past(external_mgmt_port_select))
    else $error("mdc rose while deselected");
  err_end_a: assert property (mac_rx_frame_err |-> mac_rx_frame_end)
    else $error("frame error without frame end");
  col_gate_a: assert property (
      !ext_phy_selected |=> !mac_col && !mac_crs)
    else $error("collision or carrier passed on internal path");
  // receive traffic must not leak while the internal path is chosen
  int_rx_a: assert property (
      !ext_phy_selected |=> !mac_rx_valid && !mac_rx_frame_end)
    else $error("receive passed on internal path");
  cover property (mac_tx_taken);
  cover property (mac_rx_frame_err);
  cover property ($rose(mdc));
endmodule

// >>> dv/tb_external_mii_smi_port.sv
// tb_external_mii_smi_port: scenario bench for emsp_port
// assumes emsp_phy on the pins and emsp_sva bound to the port
module tb_external_mii_smi_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, sel, ext, tx_v, m_en, m_out, m_drv, go, bad, hit;
  logic taken, rx_v, f_end, f_err, m_col, m_crs, m_in, strap, tx_clk;
  logic tx_en, rx_clk, rx_dv, rx_er, col, crs, mdc, mdio_i, mdio_o, mdio_oe;
  logic [3:0]  tx_n, rx_n, txd, rxd, cnt;
  logic [15:0] got;
  int          error_cnt = 0;
  int          cmp_count = 0;
  emsp_port emsp_port_inst (.clock, .rstn, .external_mgmt_port_select(sel),
    .ext_phy_selected(ext), .mac_tx_nibble(tx_n), .mac_tx_valid(tx_v),
    .mac_tx_taken(taken), .mac_rx_nibble(rx_n), .mac_rx_valid(rx_v),
    .mac_rx_frame_end(f_end), .mac_rx_frame_err(f_err), .mac_col(m_col),
    .mac_crs(m_crs), .mgmt_clk_en(m_en), .mgmt_out(m_out),
    .mgmt_drive(m_drv), .mgmt_in(m_in), .external_phy_present_strap(strap),
    .tx_clk, .txd, .tx_en, .rx_clk, .rxd, .rx_dv, .rx_er, .col, .crs,
    .mdc, .mdio_i, .mdio_o, .mdio_oe);
  emsp_phy emsp_phy_inst (.tx_clk, .rx_clk, .txd, .tx_en, .rxd, .rx_dv,
    .rx_er, .col, .crs, .mdio_o, .mdio_oe, .mdio_i, .go, .bad, .hit, .got,
    .cnt);
  always #4 clock = ~clock;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // three back to back nibbles, data changed at each taken pulse
  task automatic t_tx;
    ext = 1;
    for (int i = 0; i < 3; i++)
    begin
      tx_n = 4'h9 + 4'(i * 3);
      tx_v = 1;
      repeat (100)
      begin
        @(negedge clock);
        if (taken === 1'b1)
          break;
      end
    end
    tx_v = 0;
    cyc(30);
    chk("tx nibbles", 16'h09cf, {4'h0, got[11:0]});
    chk("tx count", 16'h3, {12'h0, cnt});
    chk("tx_en idle", 16'h0, {15'h0, tx_en});
    $display("test tx done");
  endtask
  // internal path: valid, collision and a whole frame offered,
  // pins stay quiet and nothing reaches the mac
  task automatic t_int;
    int n;
    ext = 0;
    tx_v = 1;
    tx_n = 4'hf;
    hit = 1;
    go = 1;
    n = 0;
    repeat (70)
    begin
      @(negedge clock);
      if (rx_v !== 1'b0 || f_end !== 1'b0)
        n++;
    end
    chk("txd internal", 16'h0, {12'h0, txd});
    chk("tx_en internal", 16'h0, {15'h0, tx_en});
    chk("col crs internal", 16'h0, {14'h0, m_col, m_crs});
    chk("rx internal", 16'h0, 16'(n));
    chk("no phy capture", 16'h3, {12'h0, cnt});
    tx_v = 0;
    hit = 0;
    go = 0;
    $display("test internal done");
  endtask
  // one frame, flagged errored only when the phy reports it
  task automatic t_rx(logic b);
    logic [15:0] seen;
    int          n;
    logic [1:0]  e;
    ext = 1;
    hit = 1;
    cyc(6);
    chk("col crs", 16'h3, {14'h0, m_col, m_crs});
    hit = 0;
    seen = 16'h0000;
    n = 0;
    e = 2'h0;
    bad = b;
    go = 1;
    repeat (120)
    begin
      @(negedge clock);
      if (rx_v === 1'b1)
      begin
        seen = {seen[11:0], rx_n};
        n++;
      end
      if (f_end === 1'b1)
        e = {1'b1, f_err};
    end
    go = 0;
    chk("rx nibbles", 16'ha5c3, seen);
    chk("rx count", 16'h4, 16'(n));
    chk("rx end err", {14'h0, 1'b1, b}, {14'h0, e});
    $display("test rx done");
  endtask
  // mdio drive, strap read back, mdc pace, then deselect
  task automatic t_mdio;
    logic p;
    int   k;
    chk("strap", 16'h1, {15'h0, strap});
    sel = 1;
    m_drv = 1;
    m_out = 1;
    cyc(3);
    chk("mdio drive high", 16'h3, {14'h0, mdio_oe, mdio_o});
    m_out = 0;
    cyc(4);
    // driven low level must come back through the input path
    chk("mdio drive low", 16'h4, {13'h0, mdio_oe, mdio_o, m_in});
    m_drv = 0;
    cyc(4);
    chk("mdio read", 16'h1, {15'h0, m_in});
    m_en = 1;
    p = mdc;
    k = 0;
    // an odd number of toggles leaves mdc high for the deselect check
    repeat (90)
    begin
      @(negedge clock);
      if (mdc !== p)
        k++;
      p = mdc;
    end
    chk("mdc toggles", 16'h3, 16'(k));
    m_drv = 1;
    sel = 0;
    cyc(2);
    chk("deselected", 16'h0, {14'h0, mdc, mdio_oe});
    $display("test mdio done");
  endtask
  initial
  begin
    clock = 0;
    rstn = 0;
    {sel, ext, tx_v, m_en, m_out, m_drv, go, bad, hit} = '0;
    tx_n = 4'h0;
    cyc(20);
    rstn = 1;
    cyc(20);
    t_tx;
    t_int;
    t_rx(1'b0);
    t_rx(1'b1);
    t_mdio;
    end_of_test;
  end
  // watchdog: the tests need about 4 us
  initial
  begin
    #20us;
    error_cnt++;
    end_of_test;
  end
endmodule
bind emsp_port emsp_sva emsp_sva_inst (.clock, .rstn, .ext_phy_selected,
  .external_mgmt_port_select, .mac_tx_taken, .mac_rx_valid,
  .mac_rx_frame_end, .mac_rx_frame_err, .mac_col, .mac_crs, .mgmt_out,
  .mgmt_drive, .txd, .tx_en, .mdc, .mdio_o, .mdio_oe);

// >>> hw/emsp_pkg.sv
// emsp_pkg: shared constants for the external mii and management port
// assumes a single 125 mhz core clock; mii clocks arrive as plain pins
// Functional notes
// - transmit nibble presented to the external phy on four data lines
// - all four transmit data lines held low while internal phy selected
// - transmit enable high exactly while transmit nibble is valid
// - transmit enable held low while internal phy selected
// - select bit one: management data pin is bidirectional toward phy
// - select bit one: management clock pin driven toward phy
// - select bit zero: management data tristated, clock held low
// - management data pin sampled as strap reporting external phy
package emsp_pkg;
  localparam int unsigned NIB_W          = 4;
  localparam logic [3:0]  NIB_RST        = 4'h0;
  localparam int unsigned SYNC_W         = 8;
  localparam int unsigned CLK_MHZ        = 125;
  // strap is captured this long after reset release
  localparam int unsigned STRAP_NS       = 80;
  localparam int unsigned STRAP_CYC      = (STRAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  STRAP_CYC_W    = 4'(STRAP_CYC);
  // management clock divider: terminal count, half period is MDC_HALF plus one core cycles
  localparam logic [5:0]  MDC_HALF       = 6'h19;
  typedef enum logic [1:0]
  {
    EMSP_STRAP_WAIT = 2'b01,
    EMSP_STRAP_DONE = 2'b10
  } emsp_strap_t;
endpackage

// >>> hw/emsp_port.sv
// emsp_port: external mii pins and management port mux
// assumes mac side on the core clock; mii clocks are sampled as pins
// and edges found; phy clock is far slower than the core clock
module emsp_port
(
  input  wire logic       clock,
  input  wire logic       rstn,
  // mac side
  input  wire logic       external_mgmt_port_select,
  input  wire logic       ext_phy_selected,
  input  wire logic [3:0] mac_tx_nibble,
  input  wire logic       mac_tx_valid,
  output logic            mac_tx_taken,
  output logic [3:0]      mac_rx_nibble,
  output logic            mac_rx_valid,
  output logic            mac_rx_frame_end,
  output logic            mac_rx_frame_err,
  output logic            mac_col,
  output logic            mac_crs,
  input  wire logic       mgmt_clk_en,
  input  wire logic       mgmt_out,
  input  wire logic       mgmt_drive,
  output logic            mgmt_in,
  output logic            external_phy_present_strap,
  // mii pins
  input  wire logic       tx_clk,
  output logic [3:0]      txd,
  output logic            tx_en,
  input  wire logic       rx_clk,
  input  wire logic [3:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  input  wire logic       col,
  input  wire logic       crs,
  // management pins
  output logic            mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe
);
  // rx bus captured on the rx_clk edge seen by the core, so the data
  // lines pass the same two stages as the clock and stay aligned
  logic [7:0] s_a;
  logic [7:0] s_b;
  emsp_sync u_sync_a
  (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({rxd, rx_dv, rx_er, col, crs}),
    .sync_out (s_a)
  );
  emsp_sync u_sync_b
  (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({tx_clk, rx_clk, mdio_i, 5'h00}),
    .sync_out (s_b)
  );

  logic [3:0] s_rxd;
  logic       s_dv;
  logic       s_er;
  logic       s_col;
  logic       s_crs;
  logic       s_txc;
  logic       s_rxc;
  logic       s_mdio;
  assign {s_rxd, s_dv, s_er, s_col, s_crs} = s_a;
  assign s_txc  = s_b[7];
  assign s_rxc  = s_b[6];
  assign s_mdio = s_b[5];

  logic       ext_on;
  assign ext_on = ext_phy_selected;

  // edge history of the sampled mii clocks
  logic       txc_d_ff;
  logic       rxc_d_ff;
  logic       tx_fall;
  logic       rx_rise;
  assign tx_fall = txc_d_ff & ~s_txc;
  assign rx_rise = ~rxc_d_ff & s_rxc;

  // transmit path state
  logic [3:0] txd_ff;
  logic [3:0] nxt_txd;
  logic       tx_en_ff;
  logic       nxt_tx_en;
  logic       taken_ff;
  logic       nxt_taken;

  // nibble drive on tx_clk fall
  // phy samples on rising edge, so we launch on the falling edge
  always_comb
  begin
    nxt_txd   = txd_ff;
    nxt_tx_en = tx_en_ff;
    nxt_taken = 1'b0;
    if (!ext_on)
    begin
      nxt_txd   = emsp_pkg::NIB_RST;
      nxt_tx_en = 1'b0;
    end
    else if (tx_fall)
    begin
      nxt_tx_en = mac_tx_valid;
      nxt_txd   = mac_tx_valid ? mac_tx_nibble : emsp_pkg::NIB_RST;
      nxt_taken = mac_tx_valid;
    end
  end

  // receive path state
  logic [3:0] rxn_ff;
  logic [3:0] nxt_rxn;
  logic       rxv_ff;
  logic       nxt_rxv;
  logic       in_frame_ff;
  logic       nxt_in_frame;
  logic       err_seen_ff;
  logic       nxt_err_seen;
  logic       end_ff;
  logic       nxt_end;
  logic       ferr_ff;
  logic       nxt_ferr;
  logic       col_ff;
  logic       nxt_col;
  logic       crs_ff;
  logic       nxt_crs;

  // rx clock edges found by sampling
  always_comb
  begin
    nxt_rxn      = rxn_ff;
    nxt_rxv      = 1'b0;
    nxt_in_frame = in_frame_ff;
    nxt_err_seen = err_seen_ff;
    nxt_end      = 1'b0;
    nxt_ferr     = 1'b0;
    nxt_col      = ext_on & s_col;
    nxt_crs      = ext_on & s_crs;
    if (!ext_on)
    begin
      nxt_in_frame = 1'b0;
      nxt_err_seen = 1'b0;
    end
    else if (rx_rise)
    begin
      if (s_dv)
      begin
        nxt_rxn      = s_rxd;
        nxt_rxv      = 1'b1;
        nxt_in_frame = 1'b1;
        nxt_err_seen = err_seen_ff | s_er;
      end
      else if (in_frame_ff)
      begin
        nxt_in_frame = 1'b0;
        nxt_end      = 1'b1;
        nxt_ferr     = err_seen_ff | s_er;
        nxt_err_seen = 1'b0;
      end
    end
  end

  // management port and strap
  emsp_pkg::emsp_strap_t strap_st_ff;
  emsp_pkg::emsp_strap_t nxt_strap_st;
  logic [3:0] strap_cnt_ff;
  logic [3:0] nxt_strap_cnt;
  logic       strap_ff;
  logic       nxt_strap;
  logic [5:0] div_ff;
  logic [5:0] nxt_div;
  logic       mdc_ff;
  logic       nxt_mdc;
  logic       mdo_ff;
  logic       nxt_mdo;
  logic       mdoe_ff;
  logic       nxt_mdoe;
  logic       mdi_ff;
  logic       nxt_mdi;

  // strap caught once after reset release
  always_comb
  begin
    nxt_strap_st  = strap_st_ff;
    nxt_strap_cnt = strap_cnt_ff;
    nxt_strap     = strap_ff;
    case (strap_st_ff)
      emsp_pkg::EMSP_STRAP_WAIT:
      begin
        nxt_strap_cnt = strap_cnt_ff + 4'h1;
        if (strap_cnt_ff == emsp_pkg::STRAP_CYC_W)
        begin
          nxt_strap    = s_mdio;
          nxt_strap_st = emsp_pkg::EMSP_STRAP_DONE;
        end
      end
      emsp_pkg::EMSP_STRAP_DONE: nxt_strap_st = emsp_pkg::EMSP_STRAP_DONE;
      default: nxt_strap_st = emsp_pkg::EMSP_STRAP_WAIT;
    endcase
  end

  // mdc is a divided core clock; the divider runs only while enabled
  always_comb
  begin
    nxt_div  = div_ff;
    nxt_mdc  = mdc_ff;
    nxt_mdo  = mgmt_out;
    nxt_mdi  = s_mdio;
    // data pin owned only when selected
    // strap window keeps the pin released so the strap is read clean
    nxt_mdoe = external_mgmt_port_select & mgmt_drive
               & (strap_st_ff == emsp_pkg::EMSP_STRAP_DONE);
    if (!external_mgmt_port_select || !mgmt_clk_en)
    begin
      nxt_div = 6'h00;
      nxt_mdc = 1'b0;
    end
    else if (div_ff == emsp_pkg::MDC_HALF)
    begin
      nxt_div = 6'h00;
      nxt_mdc = ~mdc_ff;
    end
    else
    begin
      nxt_div = div_ff + 6'h01;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      txc_d_ff     <= 1'b0;
      rxc_d_ff     <= 1'b0;
      txd_ff       <= emsp_pkg::NIB_RST;
      tx_en_ff     <= 1'b0;
      taken_ff     <= 1'b0;
      rxn_ff       <= emsp_pkg::NIB_RST;
      rxv_ff       <= 1'b0;
      in_frame_ff  <= 1'b0;
      err_seen_ff  <= 1'b0;
      end_ff       <= 1'b0;
      ferr_ff      <= 1'b0;
      col_ff       <= 1'b0;
      crs_ff       <= 1'b0;
      strap_st_ff  <= emsp_pkg::EMSP_STRAP_WAIT;
      strap_cnt_ff <= 4'h0;
      strap_ff     <= 1'b0;
      div_ff       <= 6'h00;
      mdc_ff       <= 1'b0;
      mdo_ff       <= 1'b0;
      mdoe_ff      <= 1'b0;
      mdi_ff       <= 1'b0;
    end
    else
    begin
      txc_d_ff     <= s_txc;
      rxc_d_ff     <= s_rxc;
      txd_ff       <= nxt_txd;
      tx_en_ff     <= nxt_tx_en;
      taken_ff     <= nxt_taken;
      rxn_ff       <= nxt_rxn;
      rxv_ff       <= nxt_rxv;
      in_frame_ff  <= nxt_in_frame;
      err_seen_ff  <= nxt_err_seen;
      end_ff       <= nxt_end;
      ferr_ff      <= nxt_ferr;
      col_ff       <= nxt_col;
      crs_ff       <= nxt_crs;
      strap_st_ff  <= nxt_strap_st;
      strap_cnt_ff <= nxt_strap_cnt;
      strap_ff     <= nxt_strap;
      div_ff       <= nxt_div;
      mdc_ff       <= nxt_mdc;
      mdo_ff       <= nxt_mdo;
      mdoe_ff      <= nxt_mdoe;
      mdi_ff       <= nxt_mdi;
    end
  end

  // outputs straight from flip-flops
  assign txd              = txd_ff;
  assign tx_en            = tx_en_ff;
  assign mac_tx_taken     = taken_ff;
  assign mac_rx_nibble    = rxn_ff;
  assign mac_rx_valid     = rxv_ff;
  assign mac_rx_frame_end = end_ff;
  assign mac_rx_frame_err = ferr_ff;
  assign mac_col          = col_ff;
  assign mac_crs          = crs_ff;
  assign mdc              = mdc_ff;
  assign mdio_o           = mdo_ff;
  assign mdio_oe          = mdoe_ff;
  assign mgmt_in          = mdi_ff;
  assign external_phy_present_strap = strap_ff;
endmodule

// >>> hw/emsp_sync.sv
// emsp_sync: two flip-flop synchronisers, one per bit
// assumes inputs asynchronous to clock; outputs are clean levels
module emsp_sync
(
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic [emsp_pkg::SYNC_W-1:0] async_in,
  output logic      [emsp_pkg::SYNC_W-1:0] sync_out
);
  logic [emsp_pkg::SYNC_W-1:0] meta_ff;
  logic [emsp_pkg::SYNC_W-1:0] sync_ff;
  logic [emsp_pkg::SYNC_W-1:0] nxt_meta;
  logic [emsp_pkg::SYNC_W-1:0] nxt_sync;

  // first stage is read only by the second stage
  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule
